// >>> logic/acm_att_ramp.v
`timescale 1ns/1ps
`include "acm_defs.vh"
// ****************************************************************
// Attenuator level ramp, one 0.5 dB step per interval.
// ****************************************************************
module acm_att_ramp #(
  parameter integer STEP_CYCLES = `ACM_RAMP_CYCLES
) (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_restart,
  input  wire [7:0] i_target,
  input  wire       i_mute,
  output reg  [7:0] o_level
);
  reg  [15:0] tick_q;
  wire [7:0]  goal;
  wire        tick_done;

  // Mute drives the level to full attenuation through the ramp.
  assign goal      = i_mute ? `ACM_MUTE_CODE : i_target;
  assign tick_done = (tick_q == (STEP_CYCLES - 1));

  always @(posedge i_clk) begin
    if (!i_nrst || i_restart) begin
      tick_q  <= 16'h0000;
      o_level <= `ACM_MUTE_CODE;
    end else begin
      tick_q <= tick_done ? 16'h0000 : tick_q + 16'h0001;
      if (tick_done) begin
        if (o_level < goal) begin
          o_level <= o_level + 8'h01;
        end else if (o_level > goal) begin
          o_level <= o_level - 8'h01;
        end
      end
    end
  end
endmodule

// >>> logic/acm_defs.vh
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

// ****************************************************************
// Register addresses.
// ****************************************************************
`define ACM_ADDR_W          7
`define ACM_A_SYS_CFG       7'h40
`define ACM_A_DAC_ATT_L     7'h41
`define ACM_A_DAC_ATT_R     7'h42
`define ACM_A_DAC_CLK_FMT   7'h43
`define ACM_A_DAC_OS_MUTE   7'h44
`define ACM_A_DAC_FLT_ZF    7'h45
`define ACM_A_ADC_ATT_L     7'h46
`define ACM_A_ADC_ATT_R     7'h47
`define ACM_A_ADC_CLK_FMT   7'h48
`define ACM_A_ADC_ZC_MUTE   7'h49
`define ACM_NUM_REGS        10

// ****************************************************************
// Reset values.
// ****************************************************************
`define ACM_RST_SYS_CFG     8'hf0
`define ACM_RST_DAC_ATT     8'hff
`define ACM_RST_DAC_CLK_FMT 8'h00
`define ACM_RST_DAC_OS_MUTE 8'h40
`define ACM_RST_DAC_FLT_ZF  8'h00
`define ACM_RST_ADC_ATT     8'hd7
`define ACM_RST_ADC_CLK_FMT 8'h00
`define ACM_RST_ADC_ZC_MUTE 8'h00

// ****************************************************************
// Writable bit masks, reserved bits read as zero.
// ****************************************************************
`define ACM_MSK_SYS_CFG     8'hf1
`define ACM_MSK_FULL        8'hff
`define ACM_MSK_CLK_FMT     8'hf3
`define ACM_MSK_DAC_OS_MUTE 8'h47
`define ACM_MSK_DAC_FLT_ZF  8'hf3
`define ACM_MSK_ADC_ZC_MUTE 8'h1f

// ****************************************************************
// Field positions.
// ****************************************************************
`define ACM_B_MODE_RST      7
`define ACM_B_SYS_RST       6
`define ACM_B_ADC_PSV       5
`define ACM_B_DAC_PSV       4
`define ACM_B_OUT_SE        0
`define ACM_B_CLK_SEL       7
`define ACM_F_IF_MODE       6:4
`define ACM_F_FMT           1:0
`define ACM_B_OVERSAMPLE    6
`define ACM_B_DAC_INV       2
`define ACM_B_MUTE_R        1
`define ACM_B_MUTE_L        0
`define ACM_B_ROLLOFF       7
`define ACM_F_DEEMPH_RATE   6:5
`define ACM_B_DEEMPH_EN     4
`define ACM_B_ZF_POL        1
`define ACM_B_ZF_MODE       0
`define ACM_B_ZC_DIS        4
`define ACM_B_HPF_BYP       3
`define ACM_B_ADC_INV       2

// ****************************************************************
// Clock configuration codes.
// ****************************************************************
`define ACM_CM_COMMON       2'h0
`define ACM_CM_SYNC_DIFF    2'h1
`define ACM_CM_ASYNC        2'h2

// ****************************************************************
// Timing.
// ****************************************************************
`define ACM_CLK_PERIOD_NS   5
`define ACM_RAMP_STEP_NS    100
`define ACM_RAMP_CYCLES     (`ACM_RAMP_STEP_NS / `ACM_CLK_PERIOD_NS)
`define ACM_MUTE_CODE       8'h00

`endif

// >>> logic/acm_mode_regs.v
`timescale 1ns/1ps
// Function
// - Left and right DAC attenuators span 0 dB to -127.5 dB.
// - Per-channel soft mute ramps through the attenuator.
// - DAC interface mode field selects one of eight modes.
// - Two-bit DAC format field selects one of four formats.
// - DAC clock source bit selects system clock 1 or 2.
// - Roll-off bit selects sharp or slow interpolation filter.
// - Oversample bit selects low or high modulator rate.
// - Invert bit sets normal or inverted DAC output polarity.
// - De-emphasis enable bit plus two-bit rate field.
// - Zero detect mode and zero flag polarity are selectable.
// - Common mode: converters share one clock and one interface.
// - Sync-different mode: one clock on both pins, own interfaces.
// - Async mode: each converter keeps own clock and interface.
// - Ten 8-bit registers at 0x40 to 0x49, reserved bits zero.
// - Mode register reset bit restores every register default.
// - System reset restarts data path, keeps register contents.
// - Power-save bits stop each converter until cleared.
`include "acm_defs.vh"

module acm_mode_regs #(
  parameter integer RAMP_CYCLES = `ACM_RAMP_CYCLES
) (
  input  wire       I_CORE_CLK,
  input  wire       I_NRST,
  input  wire       I_WR_EN,
  input  wire       I_RD_EN,
  input  wire [6:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  input  wire [1:0] I_CLOCK_MODE,
  input  wire       I_DAC_ZERO_L,
  input  wire       I_DAC_ZERO_R,
  output reg  [7:0] O_RDATA,
  output reg        O_RVALID,
  output reg  [7:0] O_DAC_LEVEL_L,
  output reg  [7:0] O_DAC_LEVEL_R,
  output reg        O_DAC_CLK_SEL,
  output reg  [2:0] O_DAC_IF_MODE,
  output reg  [1:0] O_DAC_FORMAT,
  output reg        O_ADC_CLK_SEL,
  output reg  [2:0] O_ADC_IF_MODE,
  output reg  [1:0] O_ADC_FORMAT,
  output reg        O_ROLLOFF_SLOW,
  output reg        O_OVERSAMPLE_HIGH,
  output reg        O_DAC_INVERT,
  output reg        O_DEEMPH_EN,
  output reg  [1:0] O_DEEMPH_RATE,
  output reg        O_ZERO_FLAG_L,
  output reg        O_ZERO_FLAG_R,
  output reg  [7:0] O_ADC_LEVEL_L,
  output reg  [7:0] O_ADC_LEVEL_R,
  output reg        O_ADC_MUTE_L,
  output reg        O_ADC_MUTE_R,
  output reg        O_ADC_ZC_DISABLE,
  output reg        O_ADC_HPF_BYPASS,
  output reg        O_ADC_INVERT,
  output reg        O_OUT_SINGLE_ENDED,
  output reg        O_DAC_RUN,
  output reg        O_ADC_RUN,
  output reg        O_DATAPATH_RST
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [7:0] regs_q [0:`ACM_NUM_REGS-1];
  reg        mode_rst_q;
  reg        sys_rst_q;
  wire [3:0] wr_idx;
  wire       wr_hit;
  wire [7:0] sys_cfg;
  wire [7:0] dac_cf;
  wire [7:0] dac_om;
  wire [7:0] dac_fz;
  wire [7:0] adc_cf;
  wire [7:0] adc_zm;
  wire [7:0] lvl_l;
  wire [7:0] lvl_r;
  wire       zero_l;
  wire       zero_r;
  genvar     g;

  function [3:0] reg_index;
    input [6:0] addr;
    begin
      reg_index = addr[3:0];
    end
  endfunction

  function addr_valid;
    input [6:0] addr;
    begin
      addr_valid = (addr >= `ACM_A_SYS_CFG) &&
                   (addr <= `ACM_A_ADC_ZC_MUTE);
    end
  endfunction

  function [7:0] reset_value;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    reset_value = `ACM_RST_SYS_CFG;
        4'h1:    reset_value = `ACM_RST_DAC_ATT;
        4'h2:    reset_value = `ACM_RST_DAC_ATT;
        4'h3:    reset_value = `ACM_RST_DAC_CLK_FMT;
        4'h4:    reset_value = `ACM_RST_DAC_OS_MUTE;
        4'h5:    reset_value = `ACM_RST_DAC_FLT_ZF;
        4'h6:    reset_value = `ACM_RST_ADC_ATT;
        4'h7:    reset_value = `ACM_RST_ADC_ATT;
        4'h8:    reset_value = `ACM_RST_ADC_CLK_FMT;
        default: reset_value = `ACM_RST_ADC_ZC_MUTE;
      endcase
    end
  endfunction

  function [7:0] write_mask;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    write_mask = `ACM_MSK_SYS_CFG;
        4'h3:    write_mask = `ACM_MSK_CLK_FMT;
        4'h4:    write_mask = `ACM_MSK_DAC_OS_MUTE;
        4'h5:    write_mask = `ACM_MSK_DAC_FLT_ZF;
        4'h8:    write_mask = `ACM_MSK_CLK_FMT;
        4'h9:    write_mask = `ACM_MSK_ADC_ZC_MUTE;
        default: write_mask = `ACM_MSK_FULL;
      endcase
    end
  endfunction

  assign wr_idx = reg_index(I_ADDR);
  assign wr_hit = I_WR_EN && addr_valid(I_ADDR);

  // ****************************************************************
  // Reset strobes; both bits act when written low, read back high.
  // ****************************************************************
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      mode_rst_q <= 1'b0;
      sys_rst_q  <= 1'b0;
    end else begin
      mode_rst_q <= wr_hit && (wr_idx == 4'h0) &&
                    !I_WDATA[`ACM_B_MODE_RST];
      sys_rst_q  <= wr_hit && (wr_idx == 4'h0) &&
                    !I_WDATA[`ACM_B_SYS_RST];
    end
  end

  generate
    for (g = 0; g < `ACM_NUM_REGS; g = g + 1) begin : g_reg
      localparam [31:0] IDX = g;
      always @(posedge I_CORE_CLK) begin
        if (!I_NRST || mode_rst_q) begin
          regs_q[g] <= reset_value(IDX[3:0]);
        end else if (wr_hit && (wr_idx == IDX[3:0])) begin
          if (g == 0) begin
            regs_q[g] <= (I_WDATA & write_mask(IDX[3:0])) |
                         `ACM_RST_SYS_CFG & 8'hc0;
          end else begin
            regs_q[g] <= I_WDATA & write_mask(IDX[3:0]);
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read port.
  // ****************************************************************
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_RDATA  <= 8'h00;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= I_RD_EN;
      if (I_RD_EN && addr_valid(I_ADDR)) begin
        O_RDATA <= regs_q[reg_index(I_ADDR)];
      end else begin
        O_RDATA <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Field extraction.
  // ****************************************************************
  assign sys_cfg = regs_q[0];
  assign dac_cf  = regs_q[3];
  assign dac_om  = regs_q[4];
  assign dac_fz  = regs_q[5];
  assign adc_cf  = regs_q[8];
  assign adc_zm  = regs_q[9];

  // ****************************************************************
  // DAC attenuators with soft mute.
  // ****************************************************************
  acm_att_ramp #(
    .STEP_CYCLES (RAMP_CYCLES)
  ) u_ramp_l (
    .i_clk     (I_CORE_CLK),
    .i_nrst    (I_NRST),
    .i_restart (sys_rst_q),
    .i_target  (regs_q[1]),
    .i_mute    (dac_om[`ACM_B_MUTE_L]),
    .o_level   (lvl_l)
  );

  acm_att_ramp #(
    .STEP_CYCLES (RAMP_CYCLES)
  ) u_ramp_r (
    .i_clk     (I_CORE_CLK),
    .i_nrst    (I_NRST),
    .i_restart (sys_rst_q),
    .i_target  (regs_q[2]),
    .i_mute    (dac_om[`ACM_B_MUTE_R]),
    .o_level   (lvl_r)
  );

  // ****************************************************************
  // Zero flags.
  // ****************************************************************
  assign zero_l = dac_fz[`ACM_B_ZF_MODE] ?
                  (I_DAC_ZERO_L && I_DAC_ZERO_R) : I_DAC_ZERO_L;
  assign zero_r = dac_fz[`ACM_B_ZF_MODE] ?
                  (I_DAC_ZERO_L && I_DAC_ZERO_R) : I_DAC_ZERO_R;

  // ****************************************************************
  // Output registers.
  // ****************************************************************
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_DAC_LEVEL_L      <= `ACM_MUTE_CODE;
      O_DAC_LEVEL_R      <= `ACM_MUTE_CODE;
      O_DAC_CLK_SEL      <= 1'b0;
      O_DAC_IF_MODE      <= 3'h0;
      O_DAC_FORMAT       <= 2'h0;
      O_ADC_CLK_SEL      <= 1'b0;
      O_ADC_IF_MODE      <= 3'h0;
      O_ADC_FORMAT       <= 2'h0;
      O_ROLLOFF_SLOW     <= 1'b0;
      O_OVERSAMPLE_HIGH  <= 1'b0;
      O_DAC_INVERT       <= 1'b0;
      O_DEEMPH_EN        <= 1'b0;
      O_DEEMPH_RATE      <= 2'h0;
      O_ZERO_FLAG_L      <= 1'b0;
      O_ZERO_FLAG_R      <= 1'b0;
      O_ADC_LEVEL_L      <= `ACM_RST_ADC_ATT;
      O_ADC_LEVEL_R      <= `ACM_RST_ADC_ATT;
      O_ADC_MUTE_L       <= 1'b0;
      O_ADC_MUTE_R       <= 1'b0;
      O_ADC_ZC_DISABLE   <= 1'b0;
      O_ADC_HPF_BYPASS   <= 1'b0;
      O_ADC_INVERT       <= 1'b0;
      O_OUT_SINGLE_ENDED <= 1'b0;
      O_DAC_RUN          <= 1'b0;
      O_ADC_RUN          <= 1'b0;
      O_DATAPATH_RST     <= 1'b1;
    end else begin
      O_DAC_LEVEL_L     <= lvl_l;
      O_DAC_LEVEL_R     <= lvl_r;
      O_ROLLOFF_SLOW    <= dac_fz[`ACM_B_ROLLOFF];
      O_OVERSAMPLE_HIGH <= dac_om[`ACM_B_OVERSAMPLE];
      O_DAC_INVERT      <= dac_om[`ACM_B_DAC_INV];
      O_DEEMPH_EN       <= dac_fz[`ACM_B_DEEMPH_EN];
      O_DEEMPH_RATE     <= dac_fz[`ACM_F_DEEMPH_RATE];
      O_ZERO_FLAG_L     <= zero_l ^ dac_fz[`ACM_B_ZF_POL];
      O_ZERO_FLAG_R     <= zero_r ^ dac_fz[`ACM_B_ZF_POL];
      O_ADC_LEVEL_L     <= regs_q[6];
      O_ADC_LEVEL_R     <= regs_q[7];
      O_ADC_MUTE_L      <= adc_zm[`ACM_B_MUTE_L];
      O_ADC_MUTE_R      <= adc_zm[`ACM_B_MUTE_R];
      O_ADC_ZC_DISABLE  <= adc_zm[`ACM_B_ZC_DIS];
      O_ADC_HPF_BYPASS  <= adc_zm[`ACM_B_HPF_BYP];
      O_ADC_INVERT      <= adc_zm[`ACM_B_ADC_INV];
      O_OUT_SINGLE_ENDED <= sys_cfg[`ACM_B_OUT_SE];
      O_DAC_RUN <= !sys_cfg[`ACM_B_DAC_PSV] && !sys_rst_q;
      O_ADC_RUN <= !sys_cfg[`ACM_B_ADC_PSV] && !sys_rst_q;
      O_DATAPATH_RST <= sys_rst_q;
      case (I_CLOCK_MODE)
        `ACM_CM_COMMON: begin
          O_DAC_CLK_SEL <= adc_cf[`ACM_B_CLK_SEL];
          O_ADC_CLK_SEL <= adc_cf[`ACM_B_CLK_SEL];
          O_DAC_IF_MODE <= adc_cf[`ACM_F_IF_MODE];
          O_DAC_FORMAT  <= adc_cf[`ACM_F_FMT];
        end
        `ACM_CM_SYNC_DIFF: begin
          O_DAC_CLK_SEL <= adc_cf[`ACM_B_CLK_SEL];
          O_ADC_CLK_SEL <= adc_cf[`ACM_B_CLK_SEL];
          O_DAC_IF_MODE <= dac_cf[`ACM_F_IF_MODE];
          O_DAC_FORMAT  <= dac_cf[`ACM_F_FMT];
        end
        default: begin
          O_DAC_CLK_SEL <= dac_cf[`ACM_B_CLK_SEL];
          O_ADC_CLK_SEL <= adc_cf[`ACM_B_CLK_SEL];
          O_DAC_IF_MODE <= dac_cf[`ACM_F_IF_MODE];
          O_DAC_FORMAT  <= dac_cf[`ACM_F_FMT];
        end
      endcase
      O_ADC_IF_MODE <= adc_cf[`ACM_F_IF_MODE];
      O_ADC_FORMAT  <= adc_cf[`ACM_F_FMT];
    end
  end

endmodule

// >>> tb/acm_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the control port.
// ****************************************************************
module acm_host_model (
  input  logic       i_clk,
  input  logic [7:0] i_rdata,
  input  logic       i_rvalid,
  output logic       o_wr_en,
  output logic       o_rd_en,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end

  // Released lines show the inverse so stale values never pass.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule

// >>> tb/acm_mode_regs_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Checker of the register port and the derived controls.
// ****************************************************************
module acm_mode_regs_chk #(
  parameter integer RAMP_CYCLES = 20
) (
  input logic       I_CORE_CLK,
  input logic       I_NRST,
  input logic       I_WR_EN,
  input logic       I_RD_EN,
  input logic [6:0] I_ADDR,
  input logic [7:0] I_WDATA,
  input logic [1:0] I_CLOCK_MODE,
  input logic [7:0] O_RDATA,
  input logic       O_RVALID,
  input logic [7:0] O_DAC_LEVEL_L,
  input logic       O_DAC_CLK_SEL,
  input logic [2:0] O_DAC_IF_MODE,
  input logic [1:0] O_DAC_FORMAT,
  input logic       O_ADC_CLK_SEL,
  input logic [2:0] O_ADC_IF_MODE,
  input logic [1:0] O_ADC_FORMAT,
  input logic       O_ROLLOFF_SLOW,
  input logic       O_OVERSAMPLE_HIGH,
  input logic       O_DAC_INVERT,
  input logic       O_DEEMPH_EN,
  input logic [1:0] O_DEEMPH_RATE,
  input logic [7:0] O_ADC_LEVEL_L,
  input logic       O_DAC_RUN,
  input logic       O_ADC_RUN,
  input logic       O_DATAPATH_RST
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  AST_RD_VALID: assert property (
    I_RD_EN |=> O_RVALID) else $error("read gave no valid");
  AST_RD_IDLE: assert property (
    !I_RD_EN |=> !O_RVALID && O_RDATA == 8'h00) else $error("idle read data");
  AST_RD_UNMAP: assert property (
    I_RD_EN && (I_ADDR < 7'h40 || I_ADDR > 7'h49) |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_LVL_STEP: assert property (
    !O_DATAPATH_RST && !$past(O_DATAPATH_RST) |->
    (O_DAC_LEVEL_L - $past(O_DAC_LEVEL_L)) inside {8'h00, 8'h01, 8'hff})
    else $error("level jumped");
  AST_SYSTEM_RESET_BIT_PULSE: assert property (
    I_WR_EN && I_ADDR == 7'h40 && I_WDATA[7] && !I_WDATA[6] |->
    ##[1:3] O_DATAPATH_RST && !O_DAC_RUN && !O_ADC_RUN)
    else $error("no data path reset");
  AST_SYSTEM_RESET_BIT_ONE: assert property (
    O_DATAPATH_RST |=> !O_DATAPATH_RST) else $error("reset pulse too long");
  AST_MODE_REGISTER_RESET: assert property (
    I_WR_EN && I_ADDR == 7'h40 && !I_WDATA[7] |->
    ##[2:4] O_ADC_LEVEL_L == 8'hd7 && !O_DAC_RUN)
    else $error("defaults not restored");
  AST_DAC_FMT: assert property (
    I_WR_EN && I_ADDR == 7'h43 && I_CLOCK_MODE[1] ##1
    !I_WR_EN && I_CLOCK_MODE[1] |=> ($past(I_WDATA, 2) & 8'hf3) ==
    {O_DAC_CLK_SEL, O_DAC_IF_MODE, 2'h0, O_DAC_FORMAT})
    else $error("dac format fields wrong");
  AST_OS_INV: assert property (
    I_WR_EN && I_ADDR == 7'h44 ##1 !I_WR_EN |=> ($past(I_WDATA, 2) &
    8'h44) == {1'b0, O_OVERSAMPLE_HIGH, 3'h0, O_DAC_INVERT, 2'h0})
    else $error("oversample or invert wrong");
  AST_FLT: assert property (
    I_WR_EN && I_ADDR == 7'h45 ##1 !I_WR_EN |=> ($past(I_WDATA, 2) &
    8'hf0) == {O_ROLLOFF_SLOW, O_DEEMPH_RATE, O_DEEMPH_EN, 4'h0})
    else $error("filter controls wrong");
  AST_COMMON: assert property (
    I_CLOCK_MODE == 2'h0 [*3] |-> {O_DAC_CLK_SEL, O_DAC_IF_MODE,
    O_DAC_FORMAT} == {O_ADC_CLK_SEL, O_ADC_IF_MODE, O_ADC_FORMAT})
    else $error("common mode differs");
  AST_SYNC_CLK: assert property (
    I_CLOCK_MODE == 2'h1 [*3] |-> O_DAC_CLK_SEL == O_ADC_CLK_SEL)
    else $error("shared clock differs");
endmodule

bind acm_mode_regs acm_mode_regs_chk #(.RAMP_CYCLES(RAMP_CYCLES))
  acm_mode_regs_chk_inst (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
  .I_WR_EN(I_WR_EN), .I_RD_EN(I_RD_EN), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_CLOCK_MODE(I_CLOCK_MODE), .O_RDATA(O_RDATA),
  .O_RVALID(O_RVALID), .O_DAC_LEVEL_L(O_DAC_LEVEL_L),
  .O_DAC_CLK_SEL(O_DAC_CLK_SEL), .O_DAC_IF_MODE(O_DAC_IF_MODE),
  .O_DAC_FORMAT(O_DAC_FORMAT), .O_ADC_CLK_SEL(O_ADC_CLK_SEL),
  .O_ADC_IF_MODE(O_ADC_IF_MODE), .O_ADC_FORMAT(O_ADC_FORMAT),
  .O_ROLLOFF_SLOW(O_ROLLOFF_SLOW), .O_OVERSAMPLE_HIGH(O_OVERSAMPLE_HIGH),
  .O_DAC_INVERT(O_DAC_INVERT), .O_DEEMPH_EN(O_DEEMPH_EN),
  .O_DEEMPH_RATE(O_DEEMPH_RATE), .O_ADC_LEVEL_L(O_ADC_LEVEL_L),
  .O_DAC_RUN(O_DAC_RUN), .O_ADC_RUN(O_ADC_RUN),
  .O_DATAPATH_RST(O_DATAPATH_RST));

// >>> tb/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the mode-control register bank.
// ****************************************************************
module testbench;
  localparam integer RAMP = 2;
  logic clk, nrst, zero_l, zero_r, wr_en, rd_en, rvalid, c_sel, os_hi;
  logic inv, rolloff_select, dm_en, zf_l, zf_r, d_run, a_run, dp_rst;
  logic a_csel, a_ml, a_mr, a_zc, a_hpf, a_inv, a_se;
  logic [1:0] clk_mode, fmt, dm_rate, a_fmt;
  logic [2:0] if_mode, a_ifm;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, lvl_l, lvl_r, a_lvl_l, a_lvl_r;
  int         failures, checks_done;

  acm_host_model acm_host_model_inst (.i_clk(clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata));
  acm_mode_regs #(.RAMP_CYCLES(RAMP)) acm_mode_regs_inst (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
    .I_ADDR(addr), .I_WDATA(wdata), .I_CLOCK_MODE(clk_mode),
    .I_DAC_ZERO_L(zero_l), .I_DAC_ZERO_R(zero_r), .O_RDATA(rdata),
    .O_RVALID(rvalid), .O_DAC_LEVEL_L(lvl_l), .O_DAC_LEVEL_R(lvl_r),
    .O_DAC_CLK_SEL(c_sel), .O_DAC_IF_MODE(if_mode), .O_DAC_FORMAT(fmt),
    .O_ADC_CLK_SEL(a_csel), .O_ADC_IF_MODE(a_ifm), .O_ADC_FORMAT(a_fmt),
    .O_ROLLOFF_SLOW(rolloff_select), .O_OVERSAMPLE_HIGH(os_hi), .O_DAC_INVERT(inv),
    .O_DEEMPH_EN(dm_en), .O_DEEMPH_RATE(dm_rate), .O_ZERO_FLAG_L(zf_l),
    .O_ZERO_FLAG_R(zf_r), .O_ADC_LEVEL_L(a_lvl_l), .O_ADC_LEVEL_R(a_lvl_r),
    .O_ADC_MUTE_L(a_ml), .O_ADC_MUTE_R(a_mr), .O_ADC_ZC_DISABLE(a_zc),
    .O_ADC_HPF_BYPASS(a_hpf), .O_ADC_INVERT(a_inv),
    .O_OUT_SINGLE_ENDED(a_se),
    .O_DAC_RUN(d_run), .O_ADC_RUN(a_run), .O_DATAPATH_RST(dp_rst));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    acm_host_model_inst.rd(a, d, v);
    cmp({7'h00, v}, 8'h01);
    cmp(d, exp);
  endtask

  task automatic wait_lvl(input logic [7:0] exp, input logic right);
    int n;
    n = 0;
    while ((right ? lvl_r : lvl_l) !== exp && n < 700) begin
      cyc(1);
      n++;
    end
    cmp(right ? lvl_r : lvl_l, exp);
  endtask

  task automatic t_defaults;
    logic [7:0] dv [10] = '{8'hf0, 8'hff, 8'hff, 8'h00, 8'h40, 8'h00,
                            8'hd7, 8'hd7, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) rd_chk(7'h40 + 7'(i), dv[i]);
    rd_chk(7'h4a, 8'h00);
    rd_chk(7'h3f, 8'h00);
  endtask

  task automatic t_masks;
    logic [7:0] mv [9] = '{8'hff, 8'hff, 8'hf3, 8'h47, 8'hf3, 8'hff,
                           8'hff, 8'hf3, 8'h1f};
    for (int i = 0; i < 9; i++) acm_host_model_inst.wr(7'h41 + 7'(i), 8'hff);
    for (int i = 0; i < 9; i++) rd_chk(7'h41 + 7'(i), mv[i]);
    cmp(a_lvl_l, 8'hff);
    cmp(a_lvl_r, 8'hff);
    cmp({3'h0, a_zc, a_hpf, a_inv, a_mr, a_ml}, 8'h1f);
  endtask

  task automatic t_ramp;
    acm_host_model_inst.wr(7'h44, 8'h40);
    acm_host_model_inst.wr(7'h41, 8'hfd);
    acm_host_model_inst.wr(7'h42, 8'h80);
    wait_lvl(8'hfd, 1'b0);
    wait_lvl(8'h80, 1'b1);
    acm_host_model_inst.wr(7'h44, 8'h41);
    cyc(4);
    cmp({7'h00, lvl_l < 8'hfd && lvl_l > 8'hf0}, 8'h01);
    wait_lvl(8'h00, 1'b0);
    cmp(lvl_r, 8'h80);
  endtask

  task automatic t_dac_fields;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], 3'(i), 2'h0, 2'(i)};
      acm_host_model_inst.wr(7'h43, d);
      cyc(2);
      cmp({c_sel, if_mode, 2'h0, fmt}, d);
    end
  endtask

  task automatic t_clock_modes;
    acm_host_model_inst.wr(7'h48, 8'ha1);
    acm_host_model_inst.wr(7'h43, 8'h52);
    clk_mode = 2'h0;
    cyc(3);
    cmp({c_sel, if_mode, 2'h0, fmt}, 8'ha1);
    clk_mode = 2'h1;
    cyc(3);
    cmp({c_sel, if_mode, 2'h0, fmt}, 8'hd2);
    clk_mode = 2'h2;
    cyc(3);
    cmp({c_sel, if_mode, 2'h0, fmt}, 8'h52);
    cmp({a_csel, a_ifm, 2'h0, a_fmt}, 8'ha1);
  endtask

  task automatic t_misc;
    logic [7:0] dv [4] = '{8'h00, 8'h92, 8'hc1, 8'h73};
    logic [1:0] ev [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
    zero_l = 1'b1;
    acm_host_model_inst.wr(7'h44, 8'h04);
    cyc(2);
    cmp({6'h00, os_hi, inv}, 8'h01);
    acm_host_model_inst.wr(7'h44, 8'h40);
    cyc(2);
    cmp({6'h00, os_hi, inv}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      acm_host_model_inst.wr(7'h45, dv[i]);
      cyc(3);
      cmp({rolloff_select, dm_rate, dm_en, 2'h0, zf_l, zf_r},
          {dv[i][7:4], 2'h0, ev[i]});
    end
    zero_r = 1'b1;
    cyc(2);
    cmp({6'h00, zf_l, zf_r}, 8'h00);
  endtask

  task automatic t_resets;
    logic seen;
    seen = 1'b0;
    acm_host_model_inst.wr(7'h41, 8'h9c);
    acm_host_model_inst.wr(7'h40, 8'hc0);
    cyc(3);
    cmp({6'h00, d_run, a_run}, 8'h03);
    acm_host_model_inst.wr(7'h40, 8'he1);
    cyc(3);
    cmp({6'h00, d_run, a_run}, 8'h02);
    cmp({7'h00, a_se}, 8'h01);
    acm_host_model_inst.wr(7'h40, 8'h80);
    repeat (4) begin
      if (dp_rst === 1'b1 && d_run === 1'b0) seen = 1'b1;
      cyc(1);
    end
    cmp({7'h00, seen}, 8'h01);
    rd_chk(7'h41, 8'h9c);
    rd_chk(7'h40, 8'hc0);
    acm_host_model_inst.wr(7'h40, 8'h40);
    cyc(3);
    rd_chk(7'h41, 8'hff);
    rd_chk(7'h40, 8'hf0);
    rd_chk(7'h46, 8'hd7);
    cmp(a_lvl_r, 8'hd7);
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    clk_mode = 2'h2;
    zero_l = 1'b0;
    zero_r = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_defaults;
    t_masks;
    t_ramp;
    t_dac_fields;
    t_clock_modes;
    t_misc;
    t_resets;
    complete_run;
  end

  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule
